//--- hdl/crs_map.svh
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
`define CRS_SP_RESET 6'h3f
`define CRS_SP_UPPER 10'h003
`define CRS_CCR_ONES 3'h7
`define CRS_CCR_H 4
`define CRS_CCR_I 3
`define CRS_CCR_N 2
`define CRS_CCR_Z 1
`define CRS_CCR_C 0
`define CRS_INT_BYTES 3'h5
`define CRS_CALL_BYTES 3'h2
`endif

//--- hdl/crs_pkg.sv
`default_nettype none
package crs_pkg;
	typedef enum logic [1:0] {
		crs_idx_none,
		crs_idx_off8,
		crs_idx_off16
	} crs_idx_e;
	typedef enum logic [2:0] {
		crs_pc_hold,
		crs_pc_inc,
		crs_pc_load,
		crs_pc_pull_hi,
		crs_pc_pull_lo
	} crs_pc_e;
	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} crs_flags_s;
	typedef struct packed {
		logic upd_nz;
		logic upd_c;
		logic upd_h;
		logic [7:0] result;
		logic carry;
		logic half;
	} crs_alu_s;
endpackage
`default_nettype wire

//--- hdl/crs_regs.sv
`include "crs_map.svh"
`default_nettype none
module crs_regs #(
	parameter int ADDR_W = 13
) (
	input wire logic clk, // core clock
	input wire logic resetn, // async reset, low
	input wire logic acc_we, // load accumulator
	input wire logic [7:0] acc_wdata, // accumulator data
	input wire logic idx_we, // load index
	input wire logic [7:0] idx_wdata, // index data
	input wire crs_pkg::crs_alu_s alu, // flag results of the executed op
	input wire logic ccr_we, // restore flags from bus
	input wire logic [7:0] ccr_wdata, // flag data
	input wire logic mask_clear_instr, // clear mask instruction
	input wire logic wait_instr, // wait instruction
	input wire logic mask_set, // interrupt entry, after stacking
	input wire logic stack_pointer_reinit_instr, // pointer reinit instruction
	input wire logic push, // one byte pushed
	input wire logic pull, // one byte pulled
	input wire logic [2:0] push_sel, // stacked item 0..4 in push order
	input wire logic [7:0] pull_data, // byte pulled from stack
	input wire logic [2:0] pull_sel, // destination of pulled byte
	input wire logic pull_we, // write pulled byte to register
	input wire crs_pkg::crs_pc_e pc_op, // program counter action
	input wire logic [15:0] pc_target, // non-sequential target
	input wire crs_pkg::crs_idx_e idx_mode, // indexed mode
	input wire logic [15:0] imm, // offset immediate
	input wire logic irq_req, // interrupt request level
	output logic [7:0] acc, // accumulator
	output logic [7:0] idx, // index register
	output logic [15:0] program_counter, // program counter
	output logic [15:0] stack_addr, // stack memory address
	output logic [5:0] stack_pointer, // pointer bits
	output logic [7:0] condition_flags_reg, // flags with upper ones
	output logic [7:0] push_data, // byte for current push
	output logic [15:0] ea, // indexed operand address
	output logic irq_take // interrupt may be serviced
);
	logic [7:0] acc_q, acc_d;
	logic [7:0] idx_q, idx_d;
	logic [5:0] sp_q, sp_d;
	logic [15:0] pc_q, pc_d;
	logic i_q, i_d;
	logic h_q, h_d, n_q, n_d, z_q, z_d, c_q, c_d;
	logic [15:0] ea_d;
	logic [15:0] pc_seq;
	logic [7:0] ccr_rd;
	logic pull_pcl, pull_pch, pull_idx, pull_acc, pull_ccr;

	// upper three bits fixed at one
	assign ccr_rd = {`CRS_CCR_ONES, h_q, i_q, n_q, z_q, c_q};
	assign condition_flags_reg = ccr_rd;
	assign acc = acc_q;
	assign idx = idx_q;
	assign stack_pointer = sp_q;
	assign program_counter = pc_q;
	assign stack_addr = {`CRS_SP_UPPER, sp_q};
	assign irq_take = irq_req & ~i_q;

	// push order: pcl, pch, x, a, ccr
	assign push_data = (push_sel == 3'h0) ? pc_q[7:0] :
		(push_sel == 3'h1) ? pc_q[15:8] :
		(push_sel == 3'h2) ? idx_q :
		(push_sel == 3'h3) ? acc_q : ccr_rd;
	assign pull_ccr = pull_we & (pull_sel == 3'h4);
	assign pull_acc = pull_we & (pull_sel == 3'h3);
	assign pull_idx = pull_we & (pull_sel == 3'h2);
	assign pull_pch = pull_we & (pull_sel == 3'h1);
	assign pull_pcl = pull_we & (pull_sel == 3'h0);

	always_comb begin
		case (idx_mode)
			crs_pkg::crs_idx_none: ea_d = {8'h00, idx_q};
			crs_pkg::crs_idx_off8: ea_d = 16'({8'h00, idx_q} + {8'h00, imm[7:0]});
			crs_pkg::crs_idx_off16: ea_d = 16'(imm + {8'h00, idx_q});
			default: ea_d = {8'h00, idx_q};
		endcase
	end
	// only implemented address lines are meaningful
	assign ea = ea_d & 16'((17'h1 << ADDR_W) - 17'h1);

	assign acc_d = pull_acc ? pull_data : (acc_we ? acc_wdata : acc_q);
	assign idx_d = pull_idx ? pull_data : (idx_we ? idx_wdata : idx_q);

	// six-bit counter wraps 00c0 -> 00ff silently
	assign sp_d = stack_pointer_reinit_instr ? `CRS_SP_RESET :
		push ? 6'(sp_q - 6'h01) :
		pull ? 6'(sp_q + 6'h01) : sp_q;

	assign pc_seq = 16'(pc_q + 16'h0001);
	always_comb begin
		case (pc_op)
			crs_pkg::crs_pc_inc: pc_d = pc_seq;
			crs_pkg::crs_pc_load: pc_d = pc_target;
			default: pc_d = pc_q;
		endcase
		if (pull_pch)
			pc_d = {pull_data, pc_q[7:0]};
		if (pull_pcl)
			pc_d = {pc_q[15:8], pull_data};
	end

	// mask: set wins over clears, restore takes stacked value
	always_comb begin
		i_d = i_q;
		if (mask_clear_instr | wait_instr)
			i_d = 1'b0;
		if (pull_ccr)
			i_d = pull_data[`CRS_CCR_I];
		else if (ccr_we)
			i_d = ccr_wdata[`CRS_CCR_I];
		if (mask_set)
			i_d = 1'b1;
	end

	always_comb begin
		h_d = h_q;
		n_d = n_q;
		z_d = z_q;
		c_d = c_q;
		if (alu.upd_h)
			h_d = alu.half;
		if (alu.upd_nz) begin
			n_d = alu.result[7];
			z_d = (alu.result == 8'h00);
		end
		if (alu.upd_c)
			c_d = alu.carry;
		if (pull_ccr | ccr_we) begin
			h_d = pull_ccr ? pull_data[`CRS_CCR_H] : ccr_wdata[`CRS_CCR_H];
			n_d = pull_ccr ? pull_data[`CRS_CCR_N] : ccr_wdata[`CRS_CCR_N];
			z_d = pull_ccr ? pull_data[`CRS_CCR_Z] : ccr_wdata[`CRS_CCR_Z];
			c_d = pull_ccr ? pull_data[`CRS_CCR_C] : ccr_wdata[`CRS_CCR_C];
		end
	end

	// registers kept through reset have no reset term
	always_ff @(posedge clk) begin
		acc_q <= acc_d;
		idx_q <= idx_d;
		h_q <= h_d;
		n_q <= n_d;
		z_q <= z_d;
		c_q <= c_d;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp_q <= `CRS_SP_RESET;
			i_q <= 1'b1;
			pc_q <= 16'h0000;
		end else begin
			sp_q <= sp_d;
			i_q <= i_d;
			pc_q <= pc_d;
		end
	end

	// helper: bytes pushed since last reinit or interrupt entry, to check interrupt frames
	logic [2:0] frame_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			frame_q <= 3'h0;
		else if (mask_set | stack_pointer_reinit_instr)
			frame_q <= 3'h0;
		else if (push)
			frame_q <= 3'(frame_q + 3'h1);
	end

	sp_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
		push && !pull && !stack_pointer_reinit_instr && sp_q == 6'h00 |=> sp_q == 6'h3f)
		else $error("stack pointer did not wrap to top");
	sp_step_a: assert property (@(posedge clk) disable iff (!resetn)
		pull && !push && !stack_pointer_reinit_instr |=> sp_q == 6'($past(sp_q) + 6'h01))
		else $error("stack pointer did not step on pull");
	sp_reinit_a: assert property (@(posedge clk) disable iff (!resetn)
		stack_pointer_reinit_instr |=> stack_addr == 16'h00ff)
		else $error("stack pointer not at top after reinit");
	stack_range_a: assert property (@(posedge clk) disable iff (!resetn)
		stack_addr[15:6] == 10'h003)
		else $error("stack address out of window");
	push_frame_a: assert property (@(posedge clk) disable iff (!resetn)
		mask_set |-> frame_q == `CRS_INT_BYTES)
		else $error("interrupt frame is not five bytes");
	ea_none_a: assert property (@(posedge clk) disable iff (!resetn)
		idx_mode == crs_pkg::crs_idx_none |-> ea == {8'h00, idx})
		else $error("no-offset address wrong");
	pc_inc_a: assert property (@(posedge clk) disable iff (!resetn)
		pc_op == crs_pkg::crs_pc_inc && !pull_we |=> program_counter == 16'($past(pc_q) + 16'h0001))
		else $error("program counter did not advance");
	pc_load_a: assert property (@(posedge clk) disable iff (!resetn)
		pc_op == crs_pkg::crs_pc_load && !pull_we |=> program_counter == $past(pc_target))
		else $error("program counter not loaded");
	ccr_ones_a: assert property (@(posedge clk) disable iff (!resetn)
		condition_flags_reg[7:5] == 3'h7)
		else $error("upper flag bits not one");
	mask_entry_a: assert property (@(posedge clk) disable iff (!resetn)
		mask_set |=> condition_flags_reg[3] && !irq_take)
		else $error("mask not set on entry");
	mask_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		i_q |-> !irq_take)
		else $error("request taken while masked");
	zero_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		alu.upd_nz && !pull_ccr && !ccr_we |=> condition_flags_reg[1] == ($past(alu.result) == 8'h00))
		else $error("zero flag wrong");
	neg_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		alu.upd_nz && !pull_ccr && !ccr_we |=> condition_flags_reg[2] == $past(alu.result[7]))
		else $error("negative flag wrong");
	mask_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		i_q && !mask_clear_instr && !wait_instr && !pull_ccr && !ccr_we |=> i_q)
		else $error("mask cleared by other means");

	acc_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!acc_we && !pull_acc |=> acc == $past(acc_q))
		else $error("accumulator changed without a write");

	acc_load_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_we && !pull_acc |=> acc == $past(acc_wdata))
		else $error("accumulator not loaded");

	idx_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!idx_we && !pull_idx |=> idx == $past(idx_q))
		else $error("index changed without a write");

	idx_load_a: assert property (@(posedge clk) disable iff (!resetn)
		idx_we && !pull_idx |=> idx == $past(idx_wdata))
		else $error("index not loaded");

	ea_off8_a: assert property (@(posedge clk) disable iff (!resetn)
		idx_mode == crs_pkg::crs_idx_off8 |-> ea[7:0] == 8'(idx + imm[7:0]))
		else $error("byte-offset address wrong");

	ea_off16_a: assert property (@(posedge clk) disable iff (!resetn)
		idx_mode == crs_pkg::crs_idx_off16 |-> ea[7:0] == 8'(idx + imm[7:0]))
		else $error("word-offset address wrong");

	ea_range_a: assert property (@(posedge clk) disable iff (!resetn)
		(ea >> ADDR_W) == 16'h0000)
		else $error("operand address beyond memory space");

	sp_push_a: assert property (@(posedge clk) disable iff (!resetn)
		push && !stack_pointer_reinit_instr |=> sp_q == 6'($past(sp_q) - 6'h01))
		else $error("stack pointer did not step on push");

	sp_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!push && !pull && !stack_pointer_reinit_instr |=> sp_q == $past(sp_q))
		else $error("stack pointer moved without a transfer");

	pull_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
		pull && !push && !stack_pointer_reinit_instr && sp_q == 6'h3f |=> sp_q == 6'h00)
		else $error("stack pointer did not wrap on pull");

	stack_low_a: assert property (@(posedge clk) disable iff (!resetn)
		stack_addr[5:0] == stack_pointer)
		else $error("stack address low bits wrong");

	pc_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		pc_op == crs_pkg::crs_pc_hold && !pull_we |=> program_counter == $past(pc_q))
		else $error("program counter moved while held");

	pc_hi_pull_a: assert property (@(posedge clk) disable iff (!resetn)
		pull_pch |=> program_counter[15:8] == $past(pull_data))
		else $error("program counter high byte not restored");

	pc_lo_pull_a: assert property (@(posedge clk) disable iff (!resetn)
		pull_pcl |=> program_counter[7:0] == $past(pull_data))
		else $error("program counter low byte not restored");

	ccr_pull_a: assert property (@(posedge clk) disable iff (!resetn)
		pull_ccr && !mask_set |=> condition_flags_reg[4:0] == $past(pull_data[4:0]))
		else $error("flags not restored from stack");

	ccr_write_a: assert property (@(posedge clk) disable iff (!resetn)
		ccr_we && !pull_ccr && !mask_set |=> condition_flags_reg[4:0] == $past(ccr_wdata[4:0]))
		else $error("flags not written");

	half_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		alu.upd_h && !pull_ccr && !ccr_we |=> condition_flags_reg[4] == $past(alu.half))
		else $error("half-carry flag wrong");

	half_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!alu.upd_h && !pull_ccr && !ccr_we |=> condition_flags_reg[4] == $past(h_q))
		else $error("half-carry flag changed");

	carry_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		alu.upd_c && !pull_ccr && !ccr_we |=> condition_flags_reg[0] == $past(alu.carry))
		else $error("carry flag wrong");

	carry_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!alu.upd_c && !pull_ccr && !ccr_we |=> condition_flags_reg[0] == $past(c_q))
		else $error("carry flag changed");

	mask_clr_op_a: assert property (@(posedge clk) disable iff (!resetn)
		(mask_clear_instr || wait_instr) && !mask_set && !pull_ccr && !ccr_we |=> !i_q)
		else $error("mask not cleared");

	irq_pass_a: assert property (@(posedge clk) disable iff (!resetn)
		irq_req && !i_q |-> irq_take)
		else $error("unmasked request not passed");

	push_pcl_a: assert property (@(posedge clk) disable iff (!resetn)
		push_sel == 3'h0 |-> push_data == program_counter[7:0])
		else $error("first stacked byte wrong");

	push_ccr_a: assert property (@(posedge clk) disable iff (!resetn)
		push_sel == 3'h4 |-> push_data == condition_flags_reg)
		else $error("last stacked byte wrong");

	acc_pull_a: assert property (@(posedge clk) disable iff (!resetn)
		pull_acc |=> acc == $past(pull_data))
		else $error("accumulator not restored");

	idx_pull_a: assert property (@(posedge clk) disable iff (!resetn)
		pull_idx |=> idx == $past(pull_data))
		else $error("index not restored");

	flag_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!alu.upd_nz && !pull_ccr && !ccr_we |=> condition_flags_reg[2:1] == $past({n_q, z_q}))
		else $error("negative or zero flag changed");
endmodule // crs_regs
`default_nettype wire

//--- bench/crs_stack_mem.sv
`default_nettype none
module crs_stack_mem (
	input wire logic clk, // core clock
	input wire logic wr, // push strobe
	input wire logic [15:0] addr, // stack address
	input wire logic [7:0] wdata, // pushed byte
	output logic [7:0] rdata // byte to pull
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [64];
	initial foreach (mem[k]) mem[k] = 8'ha5;
	// the last byte pushed sits one above the free slot
	assign rdata = mem[addr[5:0] + 6'h1];
	always @(posedge clk) if (wr) mem[addr[5:0]] <= wdata;
endmodule // crs_stack_mem
`default_nettype wire

//--- bench/crs_regs_tb.sv
`default_nettype none
module crs_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, acc_we, idx_we, ccr_we, mask_clear_instr, wait_instr, mask_set;
	logic stack_pointer_reinit_instr, push, pull, pull_we, irq_req, irq_take;
	logic [7:0] acc_wdata, idx_wdata, ccr_wdata, pull_data, acc, idx, condition_flags_reg, push_data;
	logic [2:0] push_sel, pull_sel;
	logic [15:0] pc_target, imm, program_counter, stack_addr, ea;
	logic [5:0] stack_pointer;
	logic [31:0] rs = 32'hf77a;
	logic [31:0] v;
	crs_pkg::crs_alu_s alu;
	crs_pkg::crs_pc_e pc_op;
	crs_pkg::crs_idx_e idx_mode;
	int failures, total_checks, cyc, m_sp, m_acc, m_idx, m_pc, m_f, sf, x;
	crs_regs #(.ADDR_W(13)) crs_regs_inst (.clk, .resetn, .acc_we, .acc_wdata, .idx_we,
		.idx_wdata, .alu, .ccr_we, .ccr_wdata, .mask_clear_instr, .wait_instr, .mask_set,
		.stack_pointer_reinit_instr, .push, .pull, .push_sel, .pull_data, .pull_sel, .pull_we,
		.pc_op, .pc_target, .idx_mode, .imm, .irq_req, .acc, .idx, .program_counter,
		.stack_addr, .stack_pointer, .condition_flags_reg, .push_data, .ea, .irq_take);
	crs_stack_mem crs_stack_mem_inst (.clk, .wr(push), .addr(stack_addr), .wdata(push_data),
		.rdata(pull_data));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [7:0] pbyte(int s);
		logic [7:0] t [5];
		t = '{m_pc[7:0], m_pc[15:8], m_idx[7:0], m_acc[7:0], {3'h7, m_f[4:0]}};
		return t[s];
	endfunction
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: byte %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_adr(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_all;
		chk_reg(acc, m_acc[7:0]);
		chk_reg(idx, m_idx[7:0]);
		chk_reg(condition_flags_reg, {3'h7, m_f[4:0]});
		chk_adr(program_counter, m_pc[15:0]);
		chk_adr(stack_addr, {10'h003, m_sp[5:0]});
	endtask
	task automatic nx;
		@(posedge clk);
		{acc_we, idx_we, ccr_we, mask_clear_instr, wait_instr, mask_set} <= '0;
		{stack_pointer_reinit_instr, push, pull, pull_we, alu} <= '0;
		pc_op <= crs_pkg::crs_pc_hold;
		#1;
	endtask
	task automatic results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			results();
		end
	end
	initial begin
		resetn = 1'b0;
		{acc_we, idx_we, ccr_we} = 3'h7;
		{mask_clear_instr, wait_instr, mask_set} = '0;
		{stack_pointer_reinit_instr, push, pull, pull_we, alu, irq_req} = '0;
		{acc_wdata, idx_wdata, ccr_wdata, push_sel, pull_sel, pc_target, imm} = '0;
		pc_op = crs_pkg::crs_pc_hold;
		idx_mode = crs_pkg::crs_idx_none;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		{acc_we, idx_we, ccr_we} <= '0;
		#1;
		chk_adr(stack_addr, 16'h00ff);
		chk_reg(condition_flags_reg & 8'he8, 8'he8);
		m_sp = 63;
		m_pc = 0;
		v = rnd();
		m_acc = v[7:0];
		m_idx = v[15:8];
		m_f = v[23:16] & 8'hf7;
		@(posedge clk);
		{acc_we, idx_we, ccr_we} <= 3'h7;
		{ccr_wdata, idx_wdata, acc_wdata} <= v[23:0] & 24'hf7ffff;
		nx;
		m_f = m_f & 31;
		chk_all;
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		#1;
		m_f[3] = 1'b1;
		chk_all;
		for (int k = 0; k < 12; k++) begin
			v = rnd();
			m_idx = v[31:24];
			@(posedge clk);
			idx_we <= 1'b1;
			idx_wdata <= v[31:24];
			imm <= v[15:0];
			idx_mode <= crs_pkg::crs_idx_e'(k % 3);
			nx;
			x = k % 3 == 0 ? m_idx : m_idx + (k % 3 == 1 ? v[7:0] : v[15:0]);
			chk_adr(ea, x[15:0] & 16'h1fff);
		end
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			if (k == 2) v[7:0] = 8'h00;
			@(posedge clk);
			alu <= {1'b1, k[0], 1'b1, v[7:0], v[8], v[9]};
			nx;
			if (k[0]) m_f[0] = v[8];
			m_f[4] = v[9];
			m_f[2] = v[7];
			m_f[1] = v[7:0] == 8'h00;
			chk_all;
		end
		for (int k = 0; k < 6; k++) begin
			v = rnd();
			@(posedge clk);
			pc_op <= k[0] ? crs_pkg::crs_pc_load : crs_pkg::crs_pc_inc;
			pc_target <= v[15:0];
			nx;
			m_pc = k[0] ? v[15:0] : (m_pc + 1) & 16'hffff;
			chk_adr(program_counter, m_pc[15:0]);
		end
		for (int k = 0; k < 66; k++) begin
			v = rnd() % 5;
			@(posedge clk);
			push <= 1'b1;
			push_sel <= v[2:0];
			#1;
			chk_reg(push_data, pbyte(v));
			nx;
			m_sp = (m_sp - 1) & 63;
			chk_adr(stack_addr, {10'h003, m_sp[5:0]});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			{ccr_we, ccr_wdata} <= {1'b1, 8'h08 | m_f[7:0]};
			nx;
			@(posedge clk);
			{wait_instr, mask_clear_instr} <= k[0] ? 2'h2 : 2'h1;
			nx;
			m_f[3] = 1'b0;
			chk_all;
		end
		@(posedge clk);
		stack_pointer_reinit_instr <= 1'b1;
		irq_req <= 1'b1;
		nx;
		m_sp = 63;
		chk_all;
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			push <= 1'b1;
			push_sel <= k[2:0];
			nx;
			m_sp--;
		end
		chk_reg({7'h00, irq_take}, 8'h01);
		sf = m_f;
		@(posedge clk);
		mask_set <= 1'b1;
		nx;
		m_f[3] = 1'b1;
		chk_all;
		chk_reg({7'h00, irq_take}, 8'h00);
		v = rnd();
		@(posedge clk);
		{acc_we, idx_we, ccr_we} <= 3'h7;
		{ccr_wdata, idx_wdata, acc_wdata} <= v[23:0];
		pc_op <= crs_pkg::crs_pc_load;
		pc_target <= v[31:16];
		nx;
		for (int k = 4; k >= 0; k--) begin
			@(posedge clk);
			{pull, pull_we, pull_sel} <= {2'h3, k[2:0]};
			nx;
		end
		m_sp = 63;
		m_f = sf;
		chk_all;
		chk_reg({7'h00, irq_take}, 8'h01);
		results();
	end
endmodule // crs_regs_tb
`default_nettype wire
